/* src/iras_cfg.svh */
// constants for the register access serial target and its master
`ifndef IRAS_CFG_SVH
`define IRAS_CFG_SVH
`define IRAS_ADDR_HI 6'h38
`define IRAS_DEF_TARGET 7'h70
`define IRAS_RAM_DEPTH 256
`define IRAS_CLK_KHZ 100000
`define IRAS_STD_KBPS 100
`define IRAS_FAST_KBPS 400
`define IRAS_QTR_STD ((`IRAS_CLK_KHZ + 4 * `IRAS_STD_KBPS - 1) / (4 * `IRAS_STD_KBPS))
`define IRAS_QTR_FAST ((`IRAS_CLK_KHZ + 4 * `IRAS_FAST_KBPS - 1) / (4 * `IRAS_FAST_KBPS))
`define IRAS_TIMEOUT_MS 25
`define IRAS_TIMEOUT_CYC (`IRAS_TIMEOUT_MS * `IRAS_CLK_KHZ)
`define IRAS_LV_REG 8'h1b
`define IRAS_LV_DATA 8'h80
`endif

/* src/iras_pkg.sv */
// types shared by both ends of the serial register link
package iras_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_REG = 3'h2,
    DS_WDATA = 3'h3,
    DS_RDATA = 3'h4
  } iras_dev_state_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_START = 2'h1,
    HS_BIT = 2'h2,
    HS_STOP = 2'h3
  } iras_host_state_t;
  typedef enum logic [2:0] {
    SG_ADDRW = 3'h0,
    SG_REG = 3'h1,
    SG_DATA = 3'h2,
    SG_ADDRR = 3'h3,
    SG_READ = 3'h4
  } iras_seg_t;
endpackage

/* src/iras_if.sv */
// open-drain serial link between master and target
`timescale 1ns/1ps
`default_nettype none
interface iras_if;
  logic scl_oe;
  logic scl_o;
  logic sda_oe_h;
  logic sda_o_h;
  logic sda_oe_d;
  logic sda_o_d;
  logic scl;
  logic sda;
  // pull-ups: a line is low only while someone drives it low
  assign scl = ~scl_oe | scl_o;
  assign sda = (~sda_oe_h | sda_o_h) & (~sda_oe_d | sda_o_d);
  modport host (output scl_oe, output scl_o, output sda_oe_h, output sda_o_h,
                input scl, input sda);
  modport dev (output sda_oe_d, output sda_o_d, input scl, input sda);
endinterface
`default_nettype wire

/* src/iras_dev.sv */
// serial register access target with its configuration ram
`timescale 1ns/1ps
`default_nettype none
`include "iras_cfg.svh"
module iras_dev
  import iras_pkg::*;
#(
  parameter bit HAS_LSB_PIN = 1'b0,
  parameter int TIMEOUT_CYC = `IRAS_TIMEOUT_CYC
) (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // sync reset, low
  input wire logic addr_lsb_in, // address select pin
  iras_if.dev lnk, // serial link
  output logic cfg_wr_out, // pulse: byte stored
  output logic [7:0] cfg_addr_out, // its register address
  output logic [7:0] cfg_data_out, // its value
  output logic timeout_out // pulse: transfer abandoned
);
  logic lnk_rst_n;
  logic scl_clk;
  logic sda_pos;
  logic start_tog;
  logic start_seen;
  logic start_ev;
  logic go;
  iras_dev_state_t state;
  logic [3:0] cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic sda_drv;
  logic wr_now;
  logic wr_tog;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [1:0] l1;
  logic [1:0] l2;
  logic [1:0] l3;
  logic [1:0] lstab;
  logic [6:0] own_addr;
  logic ab_s;
  logic [7:0] ram [`IRAS_RAM_DEPTH];
  logic [2:0] c1;
  logic [2:0] c2;
  logic [2:0] c3;
  logic [2:0] cstab;
  logic [31:0] to_cnt;
  logic ab_req;
  logic wr_seen;

  // link reset, taken from the core reset
  always_ff @(posedge clk_in) begin
    lnk_rst_n <= rst_n_in;
  end

  assign scl_clk = lnk.scl;
  assign lnk.sda_o_d = 1'b0;
  // release at once on abandon, without waiting for link edges
  assign lnk.sda_oe_d = sda_drv & ~ab_req & lnk_rst_n;

  // start: data falls while clock high; settles long before the clock falls
  always_ff @(negedge lnk.sda or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      start_tog <= 1'b0;
    end else if (lnk.scl) begin
      start_tog <= ~start_seen;
    end
  end

  always_ff @(posedge scl_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      sda_pos <= 1'b1;
    end else begin
      sda_pos <= lnk.sda;
    end
  end

  // pin and abandon request, three stages on the link clock
  always_ff @(negedge scl_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      l1 <= 2'h0;
      l2 <= 2'h0;
      l3 <= 2'h0;
      lstab <= 2'h0;
    end else begin
      l1 <= {addr_lsb_in, ab_req};
      l2 <= l1;
      l3 <= l2;
      lstab <= (l2 & l3) | (lstab & (l2 | l3));
    end
  end

  assign ab_s = lstab[0];
  assign own_addr = {`IRAS_ADDR_HI, HAS_LSB_PIN ? lstab[1] : 1'b0};
  assign start_ev = start_tog != start_seen;
  assign go = !ab_s && !start_ev && (state != DS_IDLE);
  assign wr_now = go && (state == DS_WDATA) && (cnt == 4'h7);

  always_ff @(negedge scl_clk) begin
    if (wr_now) begin
      ram[ptr] <= {rx[6:0], sda_pos};
    end
  end

  // byte engine: bit just sampled is sda_pos, drive changes on the fall
  always_ff @(negedge scl_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      state <= DS_IDLE;
      start_seen <= 1'b0;
      cnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      sda_drv <= 1'b0;
    end else begin
      start_seen <= start_tog;
      if (ab_s) begin
        state <= DS_IDLE;
        cnt <= 4'h0;
        sda_drv <= 1'b0;
      end else if (start_ev) begin
        state <= DS_ADDR;
        cnt <= 4'h0;
        sda_drv <= 1'b0;
      end else if (state != DS_IDLE) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        rx <= {rx[6:0], sda_pos};
        unique case (state)
          DS_ADDR: begin
            if (cnt == 4'h7) begin
              if (rx[6:0] == own_addr) begin
                sda_drv <= 1'b1;
                state <= sda_pos ? DS_RDATA : DS_REG;
              end else begin
                state <= DS_IDLE;
              end
            end
          end
          DS_REG: begin
            if (cnt == 4'h7) begin
              ptr <= {rx[6:0], sda_pos};
              sda_drv <= 1'b1;
              state <= DS_WDATA;
            end else if (cnt == 4'h8) begin
              sda_drv <= 1'b0;
            end
          end
          DS_WDATA: begin
            if (cnt == 4'h7) begin
              ptr <= ptr + 8'h01;
              sda_drv <= 1'b1;
            end else if (cnt == 4'h8) begin
              sda_drv <= 1'b0;
            end
          end
          DS_RDATA: begin
            if (cnt == 4'h8) begin
              if (!sda_pos) begin
                tx <= {ram[ptr][6:0], 1'b0};
                sda_drv <= ~ram[ptr][7];
                ptr <= ptr + 8'h01;
              end else begin
                state <= DS_IDLE;
                sda_drv <= 1'b0;
              end
            end else if (cnt == 4'h7) begin
              sda_drv <= 1'b0;
            end else begin
              sda_drv <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          end
          default: begin
            state <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // stored byte held for the core; next store is nine link bits away
  always_ff @(negedge scl_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      wr_tog <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (wr_now) begin
      wr_tog <= ~wr_tog;
      wr_addr <= ptr;
      wr_data <= {rx[6:0], sda_pos};
    end
  end

  // core side: clock level, abandon answer, store toggle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      c1 <= 3'h1;
      c2 <= 3'h1;
      c3 <= 3'h1;
      cstab <= 3'h1;
    end else begin
      c1 <= {wr_tog, ab_s, lnk.scl};
      c2 <= c1;
      c3 <= c2;
      cstab <= (c2 & c3) | (cstab & (c2 | c3));
    end
  end

  // clock held low too long: release data and abandon
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      to_cnt <= 32'h0;
      ab_req <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      timeout_out <= 1'b0;
      if (cstab[0] || ab_req || cstab[1]) begin
        to_cnt <= 32'h0;
      end else if (to_cnt == 32'(TIMEOUT_CYC - 1)) begin
        to_cnt <= 32'h0;
        ab_req <= 1'b1;
        timeout_out <= 1'b1;
      end else begin
        to_cnt <= to_cnt + 32'h1;
      end
      if (ab_req && cstab[1]) begin
        ab_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_seen <= 1'b0;
      cfg_wr_out <= 1'b0;
      cfg_addr_out <= 8'h00;
      cfg_data_out <= 8'h00;
    end else begin
      wr_seen <= cstab[2];
      cfg_wr_out <= cstab[2] != wr_seen;
      if (cstab[2] != wr_seen) begin
        cfg_addr_out <= wr_addr;
        cfg_data_out <= wr_data;
      end
    end
  end
endmodule
`default_nettype wire

/* src/iras_host.sv */
// serial bus master that writes and reads target registers
`timescale 1ns/1ps
`default_nettype none
`include "iras_cfg.svh"
module iras_host
  import iras_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // sync reset, low
  input wire logic fast_mode_in, // 1: fast rate
  input wire logic low_bus_volt_in, // bus below 2.5 V
  input wire logic cmd_valid_in, // command request
  input wire logic cmd_read_in, // 1: read
  input wire logic [6:0] cmd_target_in, // target address
  input wire logic [7:0] cmd_reg_in, // register pointer
  input wire logic [7:0] cmd_wdata_in, // write byte
  input wire logic [3:0] cmd_len_in, // read bytes, 0 as 1
  output logic cmd_ready_out, // command taken
  output logic rd_valid_out, // pulse: byte read
  output logic [7:0] rd_data_out, // byte read
  output logic done_out, // pulse: stop sent
  output logic nack_out, // pulse with done: refused
  iras_if.host lnk // serial link
);
  iras_host_state_t state;
  iras_seg_t seg;
  logic [7:0] qcnt;
  logic [7:0] qlen;
  logic tick;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [8:0] txb;
  logic [7:0] rxb;
  logic rd;
  logic [6:0] tgt;
  logic [7:0] regp;
  logic [7:0] wdat;
  logic [3:0] left;
  logic fast;
  logic nak;
  logic lv_pend;
  logic lv_go;
  logic go;
  logic s1;
  logic s2;
  logic s3;
  logic sda_s;
  logic scl_oe;
  logic sda_oe;

  assign lnk.scl_o = 1'b0;
  assign lnk.sda_o_h = 1'b0;
  assign lnk.scl_oe = scl_oe;
  assign lnk.sda_oe_h = sda_oe;
  assign lv_go = lv_pend && low_bus_volt_in;
  assign cmd_ready_out = (state == HS_IDLE) && !lv_pend;
  assign go = lv_go || (cmd_ready_out && cmd_valid_in);
  assign qlen = fast ? 8'(`IRAS_QTR_FAST) : 8'(`IRAS_QTR_STD);
  assign tick = (state != HS_IDLE) && (qcnt == qlen - 8'h01);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      s1 <= lnk.sda;
      s2 <= s1;
      s3 <= s2;
      sda_s <= (s2 & s3) | (sda_s & (s2 | s3));
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || tick || state == HS_IDLE) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= HS_IDLE;
      seg <= SG_ADDRW;
      ph <= 2'h0;
      bitn <= 4'h0;
      txb <= 9'h1ff;
      rxb <= 8'h00;
      rd <= 1'b0;
      tgt <= 7'h00;
      regp <= 8'h00;
      wdat <= 8'h00;
      left <= 4'h0;
      fast <= 1'b0;
      nak <= 1'b0;
      lv_pend <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      if (state == HS_IDLE) begin
        lv_pend <= 1'b0;
        if (go) begin
          state <= HS_START;
          seg <= SG_ADDRW;
          ph <= 2'h0;
          nak <= 1'b0;
          fast <= fast_mode_in;
          rd <= !lv_go && cmd_read_in;
          tgt <= lv_go ? `IRAS_DEF_TARGET : cmd_target_in;
          regp <= lv_go ? `IRAS_LV_REG : cmd_reg_in;
          wdat <= lv_go ? `IRAS_LV_DATA : cmd_wdata_in;
          left <= (cmd_len_in == 4'h0) ? 4'h1 : cmd_len_in;
          txb <= {lv_go ? `IRAS_DEF_TARGET : cmd_target_in, 2'b01};
        end
      end else if (tick) begin
        ph <= ph + 2'h1;
        unique case (state)
          HS_START: begin
            if (ph == 2'h0) begin
              scl_oe <= (seg == SG_ADDRR);
            end else if (ph == 2'h1) begin
              sda_oe <= 1'b0;
            end else if (ph == 2'h2) begin
              scl_oe <= 1'b0;
            end else begin
              sda_oe <= 1'b1;
              state <= HS_BIT;
              bitn <= 4'h0;
            end
          end
          HS_BIT: begin
            if (ph == 2'h0) begin
              scl_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              // data moves a quarter after the fall, never with a clock edge
              sda_oe <= ~txb[8];
            end else if (ph == 2'h2) begin
              scl_oe <= 1'b0;
            end else if (ph == 2'h3) begin
              rxb <= {rxb[6:0], sda_s};
              txb <= {txb[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                unique case (seg)
                  SG_ADDRW: begin
                    if (sda_s) begin
                      nak <= 1'b1;
                      state <= HS_STOP;
                    end else begin
                      seg <= SG_REG;
                      txb <= {regp, 1'b1};
                    end
                  end
                  SG_REG: begin
                    if (sda_s) begin
                      nak <= 1'b1;
                      state <= HS_STOP;
                    end else if (rd) begin
                      seg <= SG_ADDRR;
                      state <= HS_START;
                      txb <= {tgt, 2'b11};
                    end else begin
                      seg <= SG_DATA;
                      txb <= {wdat, 1'b1};
                    end
                  end
                  SG_DATA: begin
                    nak <= sda_s;
                    state <= HS_STOP;
                  end
                  SG_ADDRR: begin
                    if (sda_s) begin
                      nak <= 1'b1;
                      state <= HS_STOP;
                    end else begin
                      seg <= SG_READ;
                      txb <= {8'hff, left == 4'h1};
                    end
                  end
                  SG_READ: begin
                    rd_valid_out <= 1'b1;
                    rd_data_out <= rxb;
                    left <= left - 4'h1;
                    txb <= {8'hff, left == 4'h2};
                    if (left == 4'h1) begin
                      state <= HS_STOP;
                    end
                  end
                  default: begin
                    state <= HS_STOP;
                  end
                endcase
              end
            end
          end
          HS_STOP: begin
            if (ph == 2'h0) begin
              scl_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              // pulled low only once the clock is low: no false start
              sda_oe <= 1'b1;
            end else if (ph == 2'h2) begin
              scl_oe <= 1'b0;
            end else if (ph == 2'h3) begin
              sda_oe <= 1'b0;
              state <= HS_IDLE;
              done_out <= 1'b1;
              nack_out <= nak;
            end
          end
          default: begin
            state <= HS_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* test/iras_monitor.sv */
// link checks for the serial register target
`timescale 1ns/1ps
`default_nettype none
module iras_monitor
  import iras_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // sync reset, low
  input wire logic addr_lsb_in, // address select pin
  input wire logic sda_oe_d, // target pulls data low
  input wire logic scl, // clock line level
  input wire logic sda // data line level
);
  logic scl_q, sda_q, rw, acked;
  logic [3:0] pos;
  logic [7:0] nb, sr;
  logic [13:0] lo_n, dr_n;
  wire logic rise = scl & ~scl_q;
  wire logic strt = scl & scl_q & sda_q & ~sda;
  wire logic slot = rise & (pos == 4'h8);
  wire logic hit = sr[7:1] == {6'h38, addr_lsb_in};
  always_ff @(posedge clk_in) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // bit and byte position within a frame
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || strt) begin
      pos <= 4'h0;
      nb <= 8'h00;
      acked <= 1'b0;
    end else if (slot) begin
      pos <= 4'h0;
      nb <= nb + 8'h01;
      if (nb == 8'h00) acked <= sda_oe_d;
    end else if (rise) begin
      pos <= pos + 4'h1;
      sr <= {sr[6:0], sda};
      if (nb == 8'h00 && pos == 4'h7) rw <= sda;
    end
  end
  always_ff @(posedge clk_in) begin
    lo_n <= scl ? 14'h0000 : lo_n + 14'h0001;
  end
  always_ff @(posedge clk_in) begin
    dr_n <= sda_oe_d ? dr_n + 14'h0001 : 14'h0000;
  end
  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_sda_steady_high: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
    else $error("target data moved while clock high");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !sda_oe_d [*2])
    else $error("target drives data after reset");
  a_addr_ack_match: assert property (slot && nb == 8'h00 |-> sda_oe_d == hit)
    else $error("address acknowledge wrong");
  a_ack_slot_only: assert property ($rose(sda_oe_d) && !rw |-> pos == 4'h8)
    else $error("write frame driven outside ack slot");
  a_wr_ack_given: assert property (slot && !rw && acked && nb != 8'h00 |-> sda_oe_d)
    else $error("written byte not acknowledged");
  a_rd_release_ack: assert property (slot && rw && nb != 8'h00 |-> !sda_oe_d)
    else $error("target holds data in master ack slot");
  a_sda_hold_bound: assert property (dr_n < 14'h2710)
    else $error("target holds data too long");
  a_scl_low_bound: assert property (lo_n < 14'h0834)
    else $error("clock low too long");
  c_addr_ack: cover property (slot && nb == 8'h00 && sda_oe_d);
  c_addr_nack: cover property (slot && nb == 8'h00 && !sda_oe_d);
  c_burst_read: cover property (slot && rw && nb == 8'h02);
endmodule
`default_nettype wire

/* test/i2c_register_access_slave_tb.sv */
// self-checking bench: master and target joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module i2c_register_access_slave_tb
  import iras_pkg::*;
;
  typedef struct packed {
    logic rd;
    logic [6:0] tgt;
    logic [7:0] rg;
    logic [7:0] wd;
    logic [3:0] len;
    logic fast;
    logic nk;
    logic [15:0] exp;
  } iras_row_t;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic fast_mode_in = 1'b1;
  logic low_bus_volt_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic cmd_read_in = 1'b0;
  logic addr_lsb_in = 1'b0;
  logic [6:0] cmd_target_in = 7'h70;
  logic [7:0] cmd_reg_in = 8'h00;
  logic [7:0] cmd_wdata_in = 8'h00;
  logic [3:0] cmd_len_in = 4'h0;
  logic cmd_ready_out, rd_valid_out, done_out, nack_out, cfg_wr_out, timeout_out;
  logic flt_timeout, nk;
  logic flt_wr;
  logic [7:0] flt_addr, flt_data;
  logic [7:0] rd_data_out, cfg_addr_out, cfg_data_out;
  logic [7:0] rdq [$];
  int miscompares = 0;
  int n_compared = 0;
  int n_store = 0;
  int n_flt_store = 0;
  int n_to = 0;
  int cyc = 0;
  iras_row_t rows [4];
  iras_if lnk();
  iras_if lnk_flt();
  iras_host iras_host_inst (.clk_in, .rst_n_in, .fast_mode_in, .low_bus_volt_in, .cmd_valid_in,
    .cmd_read_in, .cmd_target_in, .cmd_reg_in, .cmd_wdata_in, .cmd_len_in, .cmd_ready_out,
    .rd_valid_out, .rd_data_out, .done_out, .nack_out, .lnk(lnk.host));
  iras_dev #(.HAS_LSB_PIN(1'b1), .TIMEOUT_CYC(2000)) iras_dev_inst (.clk_in, .rst_n_in,
    .addr_lsb_in, .lnk(lnk.dev), .cfg_wr_out, .cfg_addr_out, .cfg_data_out, .timeout_out);
  iras_dev #(.TIMEOUT_CYC(2000)) iras_dev_flt_inst (.clk_in, .rst_n_in, .addr_lsb_in(1'b0),
    .lnk(lnk_flt.dev), .cfg_wr_out(flt_wr), .cfg_addr_out(flt_addr),
    .cfg_data_out(flt_data), .timeout_out(flt_timeout));
  iras_monitor iras_monitor_inst (.clk_in, .rst_n_in, .addr_lsb_in, .sda_oe_d(lnk.sda_oe_d),
    .scl(lnk.scl), .sda(lnk.sda));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      print_verdict();
    end
  end
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1) rdq.push_back(rd_data_out);
    if (cfg_wr_out === 1'b1) n_store++;
    if (flt_wr === 1'b1) n_flt_store++;
    if (timeout_out === 1'b1) n_to++;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 40000) begin
      @(negedge clk_in);
      n++;
    end
    if (s !== 1'b1) miscompares++;
  endtask
  task automatic run(input iras_row_t r);
    wait_hi(cmd_ready_out);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    {cmd_read_in, cmd_target_in, cmd_reg_in, cmd_wdata_in, cmd_len_in, fast_mode_in} <=
      {r.rd, r.tgt, r.rg, r.wd, r.len, r.fast};
    rdq.delete();
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    wait_hi(done_out);
    nk = nack_out;
  endtask
  // one bit from the fault driver, clock low on entry and exit
  task automatic bb_bit(input logic b);
    lnk_flt.sda_oe_h <= ~b;
    repeat (63) @(posedge clk_in);
    lnk_flt.scl_oe <= 1'b0;
    repeat (126) @(posedge clk_in);
    lnk_flt.scl_oe <= 1'b1;
    repeat (63) @(posedge clk_in);
  endtask
  // one byte from the fault driver, left in the ack slot with data released
  task automatic bb_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) bb_bit(b[k]);
    lnk_flt.sda_oe_h <= 1'b0;
    repeat (63) @(posedge clk_in);
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    int s0;
    lnk_flt.scl_o = 1'b0;
    lnk_flt.sda_o_h = 1'b0;
    lnk_flt.scl_oe = 1'b0;
    lnk_flt.sda_oe_h = 1'b0;
    rows[0] = '{1'b0, 7'h70, 8'h05, 8'ha5, 4'h0, 1'b0, 1'b0, 16'h05a5};
    rows[1] = '{1'b0, 7'h70, 8'h06, 8'h3c, 4'h0, 1'b1, 1'b0, 16'h063c};
    rows[2] = '{1'b1, 7'h70, 8'h05, 8'h00, 4'h2, 1'b1, 1'b0, 16'ha53c};
    rows[3] = '{1'b0, 7'h72, 8'h07, 8'h11, 4'h0, 1'b1, 1'b1, 16'h063c};
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wait_hi(cmd_ready_out);
    check("lv stores", 8'(n_store), 8'h01);
    check("lv addr", cfg_addr_out, 8'h1b);
    check("lv data", cfg_data_out, 8'h80);
    foreach (rows[i]) begin
      s0 = n_store;
      run(rows[i]);
      check("nack", {7'h00, nk}, {7'h00, rows[i].nk});
      if (rows[i].rd) begin
        check("rd count", 8'(rdq.size()), {4'h0, rows[i].len});
        foreach (rdq[k]) check("rd data", rdq[k], rows[i].exp[8 - 8 * k +: 8]);
      end else begin
        check("stores", 8'(n_store - s0), {7'h00, ~rows[i].nk});
        check("store addr", cfg_addr_out, rows[i].exp[15:8]);
        check("store data", cfg_data_out, rows[i].exp[7:0]);
      end
    end
    @(posedge clk_in);
    addr_lsb_in <= 1'b1;
    run('{1'b0, 7'h71, 8'h10, 8'h5a, 4'h0, 1'b1, 1'b0, 16'h105a});
    check("lsb nack", {7'h00, nk}, 8'h00);
    check("lsb data", cfg_data_out, 8'h5a);
    run('{1'b0, 7'h70, 8'h11, 8'h22, 4'h0, 1'b1, 1'b0, 16'h0000});
    check("old addr nack", {7'h00, nk}, 8'h01);
    // mid-run reset with normal bus voltage: no low-voltage write follows
    @(posedge clk_in);
    low_bus_volt_in <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    check("rst sda", {7'h00, lnk.sda_oe_d}, 8'h00);
    check("rst ready", {7'h00, cmd_ready_out}, 8'h00);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    check("rdy edge1", {7'h00, cmd_ready_out}, 8'h00);
    @(negedge clk_in);
    check("rdy edge2", {7'h00, cmd_ready_out}, 8'h01);
    // fault driver: 70h write, pointer 40h, two data bytes, stall in last ack
    @(posedge clk_in);
    lnk_flt.sda_oe_h <= 1'b1;
    repeat (63) @(posedge clk_in);
    lnk_flt.scl_oe <= 1'b1;
    repeat (63) @(posedge clk_in);
    bb_byte(8'he0);
    check("flt ack", {7'h00, lnk_flt.sda_oe_d}, 8'h01);
    bb_bit(1'b1);
    bb_byte(8'h40);
    bb_bit(1'b1);
    bb_byte(8'h12);
    bb_bit(1'b1);
    bb_byte(8'h34);
    check("burst ack", {7'h00, lnk_flt.sda_oe_d}, 8'h01);
    check("burst stores", 8'(n_flt_store), 8'h02);
    check("burst addr", flt_addr, 8'h41);
    check("burst data", flt_data, 8'h34);
    s0 = cyc;
    wait_hi(flt_timeout);
    check("flt delay", {7'h00, (cyc - s0) >= 1800 && (cyc - s0) < 2100}, 8'h01);
    @(negedge clk_in);
    check("flt release", {7'h00, lnk_flt.sda_oe_d}, 8'h00);
    check("main timeouts", 8'(n_to), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
